// [hdl/pcdt_top.sv]
// Register block, constant-word override and two sequence checkers.
`timescale 1ns/1ps
module pcdt_top #(
  parameter int W = 16,
  parameter bit DC_TEST_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [pcdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Incoming samples
  input wire logic sample_valid,
  input wire logic [W-1:0] real_sample,
  input wire logic [W-1:0] imag_sample,
  // Outgoing samples
  output logic out_valid,
  output logic [W-1:0] real_out,
  output logic [W-1:0] imag_out
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  pcdt_pkg::pcdt_byte_t seq_ctrl;
  pcdt_pkg::pcdt_byte_t dc_high;
  pcdt_pkg::pcdt_byte_t dc_low;
  logic dc_enable;
  logic dig_spare;
  pcdt_pkg::pcdt_byte_t decode_ctrl;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One match function serves every write strobe, so a change of the
  // address width touches a single place.
  function automatic logic pcdt_hit(
    input logic [pcdt_pkg::ADDR_W-1:0] addr,
    input logic [pcdt_pkg::ADDR_W-1:0] target
  );
    return addr == target;
  endfunction : pcdt_hit

  wire wr_seq = reg_write && pcdt_hit(reg_addr, pcdt_pkg::ADDR_SEQ_CTRL);
  wire wr_dc_high = reg_write && pcdt_hit(reg_addr, pcdt_pkg::ADDR_DC_HIGH);
  wire wr_dc_low = reg_write && pcdt_hit(reg_addr, pcdt_pkg::ADDR_DC_LOW);
  wire wr_dig = reg_write && pcdt_hit(reg_addr, pcdt_pkg::ADDR_DIGITAL_TEST_CONTROL);
  wire wr_decode = reg_write && pcdt_hit(reg_addr, pcdt_pkg::ADDR_DECODE);

  // Next values are picked here so that each flip-flop block stays short.
  // On the narrow variant the constant bytes and the enable never leave zero.
  wire [7:0] next_seq_ctrl = wr_seq ? (reg_wdata & pcdt_pkg::SEQ_CTRL_MASK) : seq_ctrl;
  wire [7:0] next_dc_high = (wr_dc_high && DC_TEST_PRESENT) ? reg_wdata : dc_high; // [R6] [R8]
  wire [7:0] next_dc_low = (wr_dc_low && DC_TEST_PRESENT) ? reg_wdata : dc_low; // [R6] [R8]
  wire next_dc_enable = wr_dig ? (reg_wdata[pcdt_pkg::BIT_DC_ENABLE] && DC_TEST_PRESENT) : dc_enable; // [R7] [R8]
  wire next_dig_spare = wr_dig ? reg_wdata[pcdt_pkg::BIT_DIG_SPARE] : dig_spare;
  wire [7:0] next_decode_ctrl = wr_decode ? (reg_wdata & pcdt_pkg::DECODE_MASK) : decode_ctrl;

  // ----------------------------------------------------------------
  // Register flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      seq_ctrl <= pcdt_pkg::SEQ_CTRL_RESET; // [R1] [R2] [R3]
    end
    else
    begin
      seq_ctrl <= next_seq_ctrl;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dc_high <= pcdt_pkg::BYTE_ZERO; // [R6]
    end
    else
    begin
      dc_high <= next_dc_high;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dc_low <= pcdt_pkg::BYTE_ZERO; // [R6]
    end
    else
    begin
      dc_low <= next_dc_low;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dc_enable <= 1'b0; // [R7]
      dig_spare <= 1'b0;
    end
    else
    begin
      dc_enable <= next_dc_enable;
      dig_spare <= next_dig_spare;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      decode_ctrl <= pcdt_pkg::BYTE_ZERO;
    end
    else
    begin
      decode_ctrl <= next_decode_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Lane checkers
  // ----------------------------------------------------------------
  wire [W-1:0] lane_data [2];
  wire lane_invert [2];
  pcdt_pkg::pcdt_byte_t lane_count [2];
  logic lane_good [2];

  assign lane_data[0] = real_sample;
  assign lane_data[1] = imag_sample;
  assign lane_invert[0] = seq_ctrl[pcdt_pkg::BIT_INV_REAL]; // [R1]
  assign lane_invert[1] = seq_ctrl[pcdt_pkg::BIT_INV_IMAG]; // [R2]

  // The checkers watch the incoming samples, ahead of the override, so a
  // constant test does not count as a sequence error.
  for (genvar g = 0; g < 2; g++)
  begin : lane_gen
    pcdt_chk_if #(.W(W)) lane_bus ();
    assign lane_bus.enable = seq_ctrl[pcdt_pkg::BIT_ENABLE]; // [R10]
    assign lane_bus.clear = seq_ctrl[pcdt_pkg::BIT_CLEAR]; // [R10]
    assign lane_bus.poly = seq_ctrl[pcdt_pkg::BIT_POLY]; // [R3]
    assign lane_bus.invert = lane_invert[g];
    assign lane_bus.valid = sample_valid;
    assign lane_bus.data = lane_data[g];
    assign lane_count[g] = lane_bus.count;
    assign lane_good[g] = lane_bus.good;
    pcdt_lane_checker #(.W(W)) u_checker (
      .clk(clk),
      .reset(reset),
      .lane(lane_bus)
    );
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  wire [7:0] seq_status = (seq_ctrl & pcdt_pkg::SEQ_CTRL_MASK)
                        | ({7'h00, lane_good[0]} << pcdt_pkg::BIT_GOOD_REAL)
                        | ({7'h00, lane_good[1]} << pcdt_pkg::BIT_GOOD_IMAG); // [R9]
  wire [7:0] dig_status = ({7'h00, dc_enable} << pcdt_pkg::BIT_DC_ENABLE)
                        | ({7'h00, dig_spare} << pcdt_pkg::BIT_DIG_SPARE);

  logic [7:0] read_mux;
  always_comb
  begin
    case (reg_addr)
      pcdt_pkg::ADDR_SEQ_CTRL: read_mux = seq_status;
      pcdt_pkg::ADDR_REAL_ERR: read_mux = lane_count[0]; // [R4]
      pcdt_pkg::ADDR_IMAG_ERR: read_mux = lane_count[1]; // [R5]
      pcdt_pkg::ADDR_DC_HIGH: read_mux = dc_high;
      pcdt_pkg::ADDR_DC_LOW: read_mux = dc_low;
      pcdt_pkg::ADDR_DIGITAL_TEST_CONTROL: read_mux = dig_status;
      pcdt_pkg::ADDR_DECODE: read_mux = decode_ctrl;
      default: read_mux = pcdt_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= pcdt_pkg::BYTE_ZERO;
      reg_rdata_valid <= 1'b0;
    end
    else
    begin
      reg_rdata_valid <= reg_read;
      if (reg_read)
      begin
        reg_rdata <= read_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath with constant-word override
  // ----------------------------------------------------------------
  wire [15:0] constant_test_word = {dc_high, dc_low}; // [R6]
  wire [W-1:0] const_sample = W'(constant_test_word);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      real_out <= '0;
      imag_out <= '0;
    end
    else
    begin
      out_valid <= sample_valid;
      real_out <= dc_enable ? const_sample : real_sample; // [R7]
      imag_out <= dc_enable ? const_sample : imag_sample; // [R7]
    end
  end

endmodule : pcdt_top

// [include/pcdt_pkg.sv]
// Constants shared by the sequence checker and constant-test block.
// How it works
// [R1] Real inversion bit three, resets zero.
// [R2] Imaginary inversion bit four, resets one.
// [R3] Bit two selects seven or fifteen polynomial.
// [R4] Real channel keeps read-only eight-bit error count.
// [R5] Imaginary channel keeps its own error count.
// [R6] Constant word split over two byte registers.
// [R7] Test bit one swaps samples for constant.
// [R8] Constant test absent on the narrow variant.
// [R9] Good flags at bits six and seven.
// [R10] Enable runs checker; clear bit holds counts zero.
package pcdt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_CTRL = 10'h14B;
  localparam logic [ADDR_W-1:0] ADDR_REAL_ERR = 10'h14C;
  localparam logic [ADDR_W-1:0] ADDR_IMAG_ERR = 10'h14D;
  localparam logic [ADDR_W-1:0] ADDR_DC_HIGH = 10'h14E;
  localparam logic [ADDR_W-1:0] ADDR_DC_LOW = 10'h14F;
  localparam logic [ADDR_W-1:0] ADDR_DIGITAL_TEST_CONTROL = 10'h150;
  localparam logic [ADDR_W-1:0] ADDR_DECODE = 10'h151;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CLEAR = 1;
  localparam int BIT_POLY = 2;
  localparam int BIT_INV_REAL = 3;
  localparam int BIT_INV_IMAG = 4;
  localparam int BIT_GOOD_REAL = 6;
  localparam int BIT_GOOD_IMAG = 7;
  localparam int BIT_DC_ENABLE = 1;
  localparam int BIT_DIG_SPARE = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SEQ_CTRL_RESET = 8'h10;
  localparam logic [7:0] SEQ_CTRL_MASK = 8'h1F;
  localparam logic [7:0] DECODE_MASK = 8'hF8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Sequence taps: x^7+x^6+1 and x^15+x^14+1
  // ----------------------------------------------------------------
  localparam int HIST_W = 15;
  localparam int TAP7_A = 6;
  localparam int TAP7_B = 5;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;

  typedef logic [7:0] pcdt_byte_t;

endpackage : pcdt_pkg

// [include/pcdt_chk_if.sv]
// Control and result signals between the top and one lane checker.
`timescale 1ns/1ps
interface pcdt_chk_if #(parameter int W = 16);
  logic enable;
  logic clear;
  logic poly;
  logic invert;
  logic valid;
  logic [W-1:0] data;
  pcdt_pkg::pcdt_byte_t count;
  logic good;

  modport lane_port (input enable, input clear, input poly, input invert, input valid, input data,
    output count, output good);
  modport top (output enable, output clear, output poly, output invert, output valid, output data,
    input count, input good);
endinterface : pcdt_chk_if

// [hdl/pcdt_lane_checker.sv]
// Self-synchronising sequence checker for one sample channel.
`timescale 1ns/1ps
module pcdt_lane_checker #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control and results
  pcdt_chk_if.lane_port lane
);

  // ----------------------------------------------------------------
  // Word scan
  // ----------------------------------------------------------------
  // Each bit is predicted from the received history, MSB first, so the
  // checker locks after one word without any seed exchange.
  function automatic logic [pcdt_pkg::HIST_W:0] pcdt_scan(
    input logic [pcdt_pkg::HIST_W-1:0] hist_in,
    input logic [W-1:0] word,
    input logic poly
  );
    logic [pcdt_pkg::HIST_W-1:0] h;
    logic err;
    logic expect_bit;
    h = hist_in;
    err = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      expect_bit = poly ? (h[pcdt_pkg::TAP15_A] ^ h[pcdt_pkg::TAP15_B])
                        : (h[pcdt_pkg::TAP7_A] ^ h[pcdt_pkg::TAP7_B]); // [R3]
      if (expect_bit != word[i])
      begin
        err = 1'b1;
      end
      h = {h[pcdt_pkg::HIST_W-2:0], word[i]};
    end
    return {err, h};
  endfunction : pcdt_scan

  logic [pcdt_pkg::HIST_W-1:0] hist;
  logic primed;
  pcdt_pkg::pcdt_byte_t count;
  logic good;

  // Inverted expected data is the same as checking the complemented word.
  wire [W-1:0] word_fixed = lane.invert ? ~lane.data : lane.data; // [R1] [R2]
  wire [pcdt_pkg::HIST_W:0] scan = pcdt_scan(hist, word_fixed, lane.poly);
  wire word_err = scan[pcdt_pkg::HIST_W];
  wire check_now = lane.enable && lane.valid && primed; // [R10]
  wire saturated = (count == pcdt_pkg::COUNT_MAX);
  wire [7:0] next_count = lane.clear ? pcdt_pkg::BYTE_ZERO
                        : (check_now && word_err && !saturated) ? 8'(count + pcdt_pkg::COUNT_ONE)
                        : count; // [R4] [R5] [R10]

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hist <= '0;
      primed <= 1'b0;
      count <= pcdt_pkg::BYTE_ZERO;
      good <= 1'b0;
    end
    else
    begin
      count <= next_count;
      if (!lane.enable)
      begin
        primed <= 1'b0;
        good <= 1'b0;
      end
      else if (lane.valid)
      begin
        hist <= scan[pcdt_pkg::HIST_W-1:0];
        primed <= 1'b1;
        if (primed)
        begin
          good <= !word_err; // [R9]
        end
      end
    end
  end

  assign lane.count = count;
  assign lane.good = good;

endmodule : pcdt_lane_checker

// [dv/pcdt_top_assertions.sv]
// Concurrent checks on the register port and sample path of pcdt_top.
`timescale 1ns/1ps
module pcdt_top_assertions #(
  parameter int W = 16,
  parameter bit DC_TEST_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [pcdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  // Samples
  input wire logic sample_valid,
  input wire logic [W-1:0] real_sample,
  input wire logic [W-1:0] imag_sample,
  input wire logic out_valid,
  input wire logic [W-1:0] real_out,
  input wire logic [W-1:0] imag_out
);
  // ----------------------------------------------------------------
  // Shadow of the writable state
  // ----------------------------------------------------------------
  logic [15:0] dc_word;
  logic dc_on;
  logic clr_on;
  wire wr_high = reg_write && reg_addr == pcdt_pkg::ADDR_DC_HIGH && DC_TEST_PRESENT;
  wire wr_low = reg_write && reg_addr == pcdt_pkg::ADDR_DC_LOW && DC_TEST_PRESENT;
  wire wr_test = reg_write && reg_addr == pcdt_pkg::ADDR_DIGITAL_TEST_CONTROL && DC_TEST_PRESENT;
  wire wr_ctrl = reg_write && reg_addr == pcdt_pkg::ADDR_SEQ_CTRL;
  wire unmapped = reg_addr < pcdt_pkg::ADDR_SEQ_CTRL || reg_addr > pcdt_pkg::ADDR_DECODE;
  wire count_addr = reg_addr == pcdt_pkg::ADDR_REAL_ERR || reg_addr == pcdt_pkg::ADDR_IMAG_ERR;
  always_ff @(posedge clk)
  begin
    dc_word[15:8] <= reset ? 8'h00 : wr_high ? reg_wdata : dc_word[15:8];
    dc_word[7:0] <= reset ? 8'h00 : wr_low ? reg_wdata : dc_word[7:0];
    dc_on <= reset ? 1'b0 : wr_test ? reg_wdata[pcdt_pkg::BIT_DC_ENABLE] : dc_on;
    clr_on <= reset ? 1'b0 : wr_ctrl ? reg_wdata[pcdt_pkg::BIT_CLEAR] : clr_on;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_out_valid_lag: assert property (1'b1 |=> out_valid == $past(sample_valid)) else $error("out_valid lag");
  a_const_override: assert property (dc_on |=> real_out == $past(dc_word) && imag_out == $past(dc_word))
    else $error("constant word not driven");
  a_sample_pass: assert property (!dc_on |=> real_out == $past(real_sample) && imag_out == $past(imag_sample))
    else $error("samples not passed");
  a_read_answer: assert property (reg_read |=> reg_rdata_valid) else $error("read not answered");
  a_read_quiet: assert property (!reg_read |=> !reg_rdata_valid && $stable(reg_rdata)) else $error("read data moved");
  a_const_readback: assert property (reg_read && reg_addr == pcdt_pkg::ADDR_DC_HIGH |=> reg_rdata == $past(dc_word[15:8]))
    else $error("high byte readback");
  a_unmapped_zero: assert property (reg_read && unmapped |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_test_bits: assert property (reg_read && reg_addr == pcdt_pkg::ADDR_DIGITAL_TEST_CONTROL |=>
    reg_rdata[7:2] == 6'h00 && reg_rdata[1] == $past(dc_on)) else $error("test register bits");
  a_clear_holds: assert property (reg_read && count_addr && clr_on && $past(clr_on) |=> reg_rdata == 8'h00)
    else $error("count not held clear");
  c_const: cover property (dc_on ##1 out_valid);
  c_clear: cover property (reg_read && count_addr && clr_on);
  c_unmapped: cover property (reg_read && unmapped);
endmodule : pcdt_top_assertions

bind pcdt_top pcdt_top_assertions #(.W(W), .DC_TEST_PRESENT(DC_TEST_PRESENT)) u_chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .sample_valid(sample_valid), .real_sample(real_sample),
  .imag_sample(imag_sample), .out_valid(out_valid), .real_out(real_out), .imag_out(imag_out));

// [dv/pcdt_src.sv]
// Upstream source model: sequence words with optional inversion and a one-word error.
`timescale 1ns/1ps
module pcdt_src (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic poly,
  input wire logic inv,
  input wire logic flip,
  // Sample stream
  output logic valid,
  output logic [15:0] word
);
  logic [14:0] hist = 15'h7FFF;
  logic [15:0] w;
  logic go, p, i, f, nb;
  initial
  begin
    valid = 1'b0;
    word = 16'h0000;
  end
  // Idle words are complemented so a stale value never looks valid.
  always @(posedge clk)
  begin
    go = run;
    p = poly;
    i = inv;
    f = flip;
    #1;
    if (go)
      for (int k = 15; k >= 0; k--)
      begin
        nb = p ? hist[14] ^ hist[13] : hist[6] ^ hist[5];
        w[k] = nb;
        hist = {hist[13:0], nb};
      end
    valid = go;
    word = go ? w ^ {16{i}} ^ {15'h0000, f} : ~word;
  end
endmodule : pcdt_src

// [dv/tb.sv]
// Self-checking bench for pcdt_top fed by two upstream sources.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata, rdata2, ctl;
  logic rvalid, ovalid, sv;
  logic [15:0] rs, iw, ro, io, s, si;
  logic run = 1'b0;
  logic poly = 1'b0;
  logic flip = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  // Row: address, write flag, write data, expected read.
  logic [26:0] rows [15] = '{{10'h14B, 9'h000, 8'h10}, {10'h14C, 9'h000, 8'h00}, {10'h14D, 9'h000, 8'h00},
    {10'h14E, 9'h000, 8'h00}, {10'h14F, 9'h000, 8'h00}, {10'h150, 9'h000, 8'h00}, {10'h151, 9'h000, 8'h00},
    {10'h14E, 9'h1FF, 8'hFF}, {10'h14F, 9'h1A5, 8'hA5}, {10'h150, 9'h1FF, 8'h03}, {10'h151, 9'h1FF, 8'hF8},
    {10'h14B, 9'h13F, 8'h1F}, {10'h14B, 9'h110, 8'h10}, {10'h14C, 9'h1FF, 8'h00}, {10'h3FF, 9'h1FF, 8'h00}};
  always #12.5 clk = ~clk;
  pcdt_src u_real (.clk(clk), .run(run), .poly(poly), .inv(1'b0), .flip(flip), .valid(sv), .word(rs));
  pcdt_src u_imag (.clk(clk), .run(run), .poly(poly), .inv(1'b1), .flip(1'b0), .valid(), .word(iw));
  pcdt_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rdata_valid(rvalid), .sample_valid(sv), .real_sample(rs),
    .imag_sample(iw), .out_valid(ovalid), .real_out(ro), .imag_out(io));
  pcdt_top #(.DC_TEST_PRESENT(1'b0)) dut_narrow (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(rdata2), .reg_rdata_valid(),
    .sample_valid(sv), .real_sample(rs), .imag_sample(iw), .out_valid(), .real_out(), .imag_out());
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #1 reg_read = 1'b0;
    #1 chk("rdata_valid", {15'h0000, rvalid}, 16'h0001);
    chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask : rd
  task results;
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  initial
  begin
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i][16])
        wr(rows[i][26:17], rows[i][15:8]);
      rd(rows[i][26:17], rows[i][7:0]);
    end
    rd(10'h14E, 8'hFF);
    chk("narrow_const", {8'h00, rdata2}, 16'h0000);
    @(posedge clk);
    #1 run = 1'b1;
    repeat (3) @(posedge clk);
    #2 chk("real_const", ro, 16'hFFA5);
    chk("imag_const", io, 16'hFFA5);
    wr(10'h150, 8'h00);
    @(posedge clk);
    #2 s = rs;
    si = iw;
    @(posedge clk);
    #2 chk("real_pass", ro, s);
    chk("imag_pass", io, si);
    chk("out_valid", {15'h0000, ovalid}, 16'h0001);
    for (int p = 0; p < 2; p++)
    begin
      ctl = {5'b00010, p[0], 2'b01};
      @(posedge clk);
      #1 poly = p[0];
      wr(10'h14B, ctl);
      repeat (40) @(posedge clk);
      wr(10'h14B, ctl | 8'h02);
      wr(10'h14B, ctl);
      rd(10'h14C, 8'h00);
      rd(10'h14B, ctl | 8'hC0);
      @(posedge clk);
      #1 flip = 1'b1;
      @(posedge clk);
      #1 flip = 1'b0;
      repeat (4) @(posedge clk);
      rd(10'h14C, 8'h02);
      rd(10'h14D, 8'h00);
    end
    wr(10'h14B, 8'h1D);
    repeat (300) @(posedge clk);
    rd(10'h14C, 8'hFF);
    rd(10'h14B, 8'h9D);
    wr(10'h14B, 8'h05);
    repeat (300) @(posedge clk);
    rd(10'h14D, 8'hFF);
    rd(10'h14B, 8'h45);
    wr(10'h14B, 8'h1F);
    rd(10'h14C, 8'h00);
    rd(10'h14D, 8'h00);
    wr(10'h14B, 8'h10);
    rd(10'h14B, 8'h10);
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    chk("reset_out_valid", {15'h0000, ovalid}, 16'h0000);
    chk("reset_real_out", ro, 16'h0000);
    rd(10'h14B, 8'h10);
    rd(10'h14E, 8'h00);
    rd(10'h14F, 8'h00);
    rd(10'h150, 8'h00);
    results;
  end
endmodule : tb
